// File: rtl/gsf_general_flags.sv
// General status flags word, its mask, alarm summary and slew control.
// Assumes condition sources on pclk give one-cycle event pulses; only
// the supply comparator arrives asynchronously.
`timescale 1ns/1ps
module gsf_general_flags (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire gsf_pkg::gsf_apb_req_t apb_req,
    output      gsf_pkg::gsf_apb_rsp_t apb_rsp,
    input  wire gsf_pkg::gsf_cond_t    cond,
    output      logic               general_irq_summary,
    output      logic               slew_enable
);
    import gsf_pkg::*;

    localparam int SLEW_MAX = 3;

    gsf_state_t s_q;
    gsf_state_t s_d;

    logic        setup;
    logic        acc;
    logic [15:0] live;
    logic [15:0] ev;
    logic [15:0] clr;
    logic [15:0] src;
    logic        supply_nx;

    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    always_comb begin
        s_d       = s_q;
        setup     = apb_req.psel & ~apb_req.penable;
        acc       = apb_req.psel & apb_req.penable & s_q.ready;
        live      = '0;
        ev        = '0;
        clr       = '0;
        src       = GSF_IRQ_SRC;
        supply_nx = s_q.flags[GSF_B_SUPPLY];
        if (ce) begin
            s_d.sync = {s_q.sync[1:0], cond.supply_cmp};
            // Filter: a change counts only when stages two and three agree
            if (s_q.sync[2] == s_q.sync[1]) begin
                supply_nx = s_q.sync[2];
            end
            live[GSF_B_ALARM]  = |(cond.alarm_flags & ~cond.alarm_mask);
            live[GSF_B_TRIM]   = cond.trim_busy;
            // Slewing off means the code jumps, so done is immediate
            live[GSF_B_SLEW]   = (cond.applied_code == cond.target_code) | ~s_q.slew_en;
            live[GSF_B_ADCBSY] = cond.adc_busy;
            live[GSF_B_SUPPLY] = supply_nx;
            ev[GSF_B_EOC]      = cond.adc_eoc;
            ev[GSF_B_BRKFRM]   = cond.brk_frame_err;
            ev[GSF_B_BRKPAR]   = cond.brk_parity_err;
            ev[GSF_B_RXFRM]    = cond.rx_frame_err;
            ev[GSF_B_RXPAR]    = cond.rx_parity_err;
            // Clear only what the read returned; new events win
            if (acc && !apb_req.pwrite && hit(apb_req.paddr, GSF_IDX_FLAGS)) begin
                clr = s_q.snap & GSF_STICKY;
            end
            s_d.flags = ((((s_q.flags & ~clr) | ev) & GSF_STICKY) | live) & ~GSF_RSVD;
            // Slew done raises an event only while slewing is on
            if (!s_q.slew_en) begin
                src[GSF_B_SLEW] = 1'b0;
            end
            s_d.summary = |(s_q.flags & ~s_q.mask & src);
            s_d.ready   = setup;
            s_d.slverr  = 1'b0;
            if (setup) begin
                s_d.snap  = '0;
                s_d.rdata = '0;
                if (hit(apb_req.paddr, GSF_IDX_FLAGS)) begin
                    s_d.snap  = s_q.flags;
                    s_d.rdata = {16'h0000, s_q.flags};
                end else if (hit(apb_req.paddr, GSF_IDX_MASK)) begin
                    s_d.rdata = {16'h0000, s_q.mask};
                end else if (hit(apb_req.paddr, GSF_IDX_ALARM)) begin
                    s_d.rdata[GSF_B_SUMMARY] = s_q.summary;
                end else if (hit(apb_req.paddr, GSF_IDX_SLEW)) begin
                    s_d.rdata[GSF_B_SLEWEN] = s_q.slew_en;
                end else begin
                    s_d.slverr = 1'b1;
                end
                if (apb_req.pwrite) begin
                    s_d.rdata = '0;
                    s_d.snap  = '0;
                end
            end
            if (acc && apb_req.pwrite && apb_req.pstrb[0]) begin
                if (hit(apb_req.paddr, GSF_IDX_MASK)) begin
                    s_d.mask = (apb_req.pwdata[15:0] & GSF_MASK_WR) | GSF_MASK_FIXED;
                end else if (hit(apb_req.paddr, GSF_IDX_SLEW)) begin
                    // Clearing this early makes the output step at once
                    s_d.slew_en = apb_req.pwdata[GSF_B_SLEWEN];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.sync    <= '0;
            s_q.flags   <= GSF_FLAGS_RST;
            s_q.mask    <= GSF_MASK_RST;
            s_q.snap    <= '0;
            s_q.rdata   <= '0;
            s_q.ready   <= 1'b0;
            s_q.slverr  <= 1'b0;
            s_q.slew_en <= 1'b0;
            s_q.summary <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // One driver for the whole response struct
    assign apb_rsp              = {s_q.rdata, s_q.ready, s_q.slverr};
    assign general_irq_summary  = s_q.summary;
    assign slew_enable          = s_q.slew_en;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_flags_setup_read;
        ce && apb_req.psel && !apb_req.penable && !apb_req.pwrite
            && hit(apb_req.paddr, GSF_IDX_FLAGS);
    endsequence

    sequence s_alarm_setup_read;
        ce && apb_req.psel && !apb_req.penable && !apb_req.pwrite
            && hit(apb_req.paddr, GSF_IDX_ALARM);
    endsequence

    sequence s_target_moved;
        ce && !s_q.slew_en && $changed(cond.target_code);
    endsequence

    a_alarm_or: assert property (
        ce |=> s_q.flags[GSF_B_ALARM] == $past(|(cond.alarm_flags & ~cond.alarm_mask)))
        else $error("alarm summary bit wrong");

    a_trim_busy: assert property (
        ce |=> s_q.flags[GSF_B_TRIM] == $past(cond.trim_busy))
        else $error("trim busy bit wrong");

    a_reset_sticky: assert property (
        ce && s_q.flags[GSF_B_RESET] && !s_q.snap[GSF_B_RESET] |=> s_q.flags[GSF_B_RESET])
        else $error("reset marker lost without read");

    a_reset_no_irq: assert property (
        ce && ((s_q.flags & ~s_q.mask & GSF_IRQ_SRC) == 16'h0000) |=> !s_q.summary)
        else $error("status-only bit reached summary");

    a_slew_done: assert property (
        ce && (cond.applied_code == cond.target_code) |=> s_q.flags[GSF_B_SLEW])
        else $error("slew done missing at target");

    a_slew_busy: assert property (
        ce && s_q.slew_en && (cond.applied_code != cond.target_code)
            |=> !s_q.flags[GSF_B_SLEW])
        else $error("slew done while moving");

    a_slew_off_fast: assert property (
        s_target_moved |-> ##[1:SLEW_MAX] s_q.flags[GSF_B_SLEW])
        else $error("slew done late with slewing off");

    a_slew_event: assert property (
        ce && s_q.slew_en && s_q.flags[GSF_B_SLEW] && !s_q.mask[GSF_B_SLEW]
            |=> s_q.summary)
        else $error("slew event not raised");

    a_eoc_set: assert property (
        ce && cond.adc_eoc |=> s_q.flags[GSF_B_EOC])
        else $error("end of conversion not caught");

    a_adc_busy: assert property (
        ce |=> s_q.flags[GSF_B_ADCBSY] == $past(cond.adc_busy))
        else $error("converter busy not live");

    a_supply_agree: assert property (
        ce && (s_q.sync[2] == s_q.sync[1]) |=> s_q.flags[GSF_B_SUPPLY] == $past(s_q.sync[2]))
        else $error("supply flag not following filter");

    a_brk_frame: assert property (
        ce && cond.brk_frame_err |=> s_q.flags[GSF_B_BRKFRM])
        else $error("break stop error lost");

    a_brk_parity: assert property (
        ce && cond.brk_parity_err |=> s_q.flags[GSF_B_BRKPAR])
        else $error("break parity error lost");

    a_rx_frame: assert property (
        ce && cond.rx_frame_err |=> s_q.flags[GSF_B_RXFRM])
        else $error("character stop error lost");

    a_rx_parity: assert property (
        ce && cond.rx_parity_err |=> s_q.flags[GSF_B_RXPAR])
        else $error("character parity error lost");

    a_rsvd_zero: assert property (
        (s_q.flags & GSF_RSVD) == 16'h0000)
        else $error("reserved flag bits set");

    a_mask_blocks: assert property (
        ce && (s_q.mask == GSF_MASK_RST) |=> !s_q.summary)
        else $error("masked flag raised summary");

    a_summary_read: assert property (
        s_alarm_setup_read |=> apb_rsp.pready
            && apb_rsp.prdata[GSF_B_SUMMARY] == $past(s_q.summary))
        else $error("alarm word summary readback wrong");

    a_read_snap: assert property (
        s_flags_setup_read |=> apb_rsp.prdata[15:0] == $past(s_q.flags))
        else $error("flags read not a snapshot");

    a_read_clears: assert property (
        s_flags_setup_read ##1 (ce && apb_req.psel && apb_req.penable
            && s_q.snap[GSF_B_RXPAR] && !cond.rx_parity_err)
            |=> !s_q.flags[GSF_B_RXPAR])
        else $error("sticky bit not cleared by read");

    a_read_no_loss: assert property (
        ce && s_q.ready && apb_req.penable && cond.rx_parity_err |=> s_q.flags[GSF_B_RXPAR])
        else $error("event lost during read clear");

    a_one_wait: assert property (
        ce && apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 (!ce || !apb_rsp.pready))
        else $error("pready not a single access cycle");

endmodule : gsf_general_flags

// File: rtl/gsf_pkg.sv
// General status flags block: constants, register map, carrier types.
// Assumes an APB master on pclk and condition sources on the same clock,
// except the supply comparator, which is asynchronous.
// How it works
// - Bit 15 ORs all unmasked alarm flags
// - Bit 12 shows trim copy in progress
// - Bit 8 sticky reset marker, never interrupts
// - Bit 7 high once applied equals target
// - Slewing off: done within three cycles
// - Slewing on: reaching target raises interrupt
// - Bit 6 sticky end of conversion, maskable
// - Bit 5 live converter busy, status only
// - Bit 4 mirrors supply comparator, status only
// - Bit 3 sticky break stop bit error
// - Bit 2 sticky break parity error
// - Bit 1 sticky character stop bit error
// - Bit 0 sticky character parity error
// - Reset value 1180h, reserved bits zero
// - Mask bit one blocks flag from interrupt
// - Alarm word summary ORs unmasked flags 6 and 3-0, and flag 7 only while slewing is on
package gsf_pkg;

    // Register word indices; byte address is index times four
    localparam logic [9:0]  GSF_IDX_MASK    = 10'h01E;
    localparam logic [9:0]  GSF_IDX_ALARM   = 10'h020;
    localparam logic [9:0]  GSF_IDX_FLAGS   = 10'h021;
    localparam logic [9:0]  GSF_IDX_SLEW    = 10'h030;

    localparam logic [15:0] GSF_FLAGS_RST   = 16'h1180;
    localparam logic [15:0] GSF_MASK_RST    = 16'hFFFF;
    localparam logic [15:0] GSF_MASK_WR     = 16'h00CF;
    localparam logic [15:0] GSF_MASK_FIXED  = 16'hFF30;
    localparam logic [15:0] GSF_STICKY      = 16'h014F;
    localparam logic [15:0] GSF_IRQ_SRC     = 16'h00CF;
    localparam logic [15:0] GSF_RSVD        = 16'h6E00;

    localparam int GSF_B_ALARM   = 15;
    localparam int GSF_B_TRIM    = 12;
    localparam int GSF_B_RESET   = 8;
    localparam int GSF_B_SLEW    = 7;
    localparam int GSF_B_EOC     = 6;
    localparam int GSF_B_ADCBSY  = 5;
    localparam int GSF_B_SUPPLY  = 4;
    localparam int GSF_B_BRKFRM  = 3;
    localparam int GSF_B_BRKPAR  = 2;
    localparam int GSF_B_RXFRM   = 1;
    localparam int GSF_B_RXPAR   = 0;
    localparam int GSF_B_SUMMARY = 15;
    localparam int GSF_B_SLEWEN  = 0;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } gsf_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gsf_apb_rsp_t;

    typedef struct packed {
        logic [15:0] alarm_flags;
        logic [15:0] alarm_mask;
        logic        trim_busy;
        logic [15:0] applied_code;
        logic [15:0] target_code;
        logic        adc_eoc;
        logic        adc_busy;
        logic        supply_cmp;
        logic        brk_frame_err;
        logic        brk_parity_err;
        logic        rx_frame_err;
        logic        rx_parity_err;
    } gsf_cond_t;

    typedef struct packed {
        logic [2:0]  sync;
        logic [15:0] flags;
        logic [15:0] mask;
        logic [15:0] snap;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        slew_en;
        logic        summary;
    } gsf_state_t;

endpackage : gsf_pkg

// File: verif/gsf_general_flags_test.sv
// Self-checking bench for the general status flags block.
// Assumes the design answers APB with its own pready; ce held high except in the frozen clock enable check.
`timescale 1ns/1ps
module gsf_general_flags_test;
    import gsf_pkg::*;

    localparam logic [11:0] A_MASK  = {GSF_IDX_MASK, 2'b00};
    localparam logic [11:0] A_ALARM = {GSF_IDX_ALARM, 2'b00};
    localparam logic [11:0] A_FLAGS = {GSF_IDX_FLAGS, 2'b00};
    localparam logic [11:0] A_SLEW  = {GSF_IDX_SLEW, 2'b00};
    localparam logic [11:0] A_BAD   = 12'h004;

    logic         pclk;
    logic         presetn;
    logic         ce;
    gsf_apb_req_t req;
    gsf_apb_rsp_t rsp;
    gsf_cond_t    cond;
    logic         irq;
    logic         slew_en;
    logic [31:0]  rd;
    logic         err;
    int           errors      = 0;
    int           checks_done = 0;
    int           cycles      = 0;
    int           ev_bits[5]  = '{0, 1, 2, 3, 6};

    gsf_general_flags dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .ce                  (ce),
        .apb_req             (req),
        .apb_rsp             (rsp),
        .cond                (cond),
        .general_irq_summary (irq),
        .slew_enable         (slew_en)
    );

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // Whole run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    task tally_and_finish();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // Waits on pready with no assumed latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= d;
        req.pstrb   <= 4'hF;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(rd, exp);
    endtask : rd_chk

    task pulse(input int b);
        @(posedge pclk);
        case (b)
            0: cond.rx_parity_err <= 1'b1;
            1: cond.rx_frame_err <= 1'b1;
            2: cond.brk_parity_err <= 1'b1;
            3: cond.brk_frame_err <= 1'b1;
            default: cond.adc_eoc <= 1'b1;
        endcase
        @(posedge pclk);
        cond.rx_parity_err  <= 1'b0;
        cond.rx_frame_err   <= 1'b0;
        cond.brk_parity_err <= 1'b0;
        cond.brk_frame_err  <= 1'b0;
        cond.adc_eoc        <= 1'b0;
    endtask : pulse

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        req = '0;
        cond = '0;
        cond.alarm_mask = 16'hFFFF;
        cond.trim_busy = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(A_FLAGS, 32'h1180);
        rd_chk(A_FLAGS, 32'h1080);
        cond.trim_busy <= 1'b0;
        rd_chk(A_FLAGS, 32'h0080);
        rd_chk(A_MASK, 32'hFFFF);
        rd_chk(A_ALARM, 32'h0000);
        apb(1'b1, A_MASK, 32'h0);
        rd_chk(A_MASK, 32'hFF30);
        apb(1'b0, A_BAD, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        // Each sticky source sets, survives until read, then clears
        foreach (ev_bits[i]) begin
            pulse(ev_bits[i]);
            rd_chk(A_FLAGS, 32'h80 | (32'h1 << ev_bits[i]));
            rd_chk(A_FLAGS, 32'h80);
        end
        pulse(0);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b1);
        rd_chk(A_ALARM, 32'h8000);
        rd_chk(A_FLAGS, 32'h0081);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b0);
        apb(1'b1, A_MASK, 32'h1);
        pulse(0);
        repeat (2) @(posedge pclk);
        chk_bit(irq, 1'b0);
        rd_chk(A_FLAGS, 32'h0081);
        // Live converter busy and supply bits never reach the summary
        cond.adc_busy <= 1'b1;
        cond.supply_cmp <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_bit(irq, 1'b0);
        rd_chk(A_FLAGS, 32'h00B0);
        cond.adc_busy <= 1'b0;
        cond.supply_cmp <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_chk(A_FLAGS, 32'h0080);
        cond.alarm_flags <= 16'h0004;
        cond.alarm_mask <= 16'hFFFB;
        repeat (2) @(posedge pclk);
        rd_chk(A_FLAGS, 32'h8080);
        cond.alarm_mask <= 16'hFFFF;
        repeat (2) @(posedge pclk);
        rd_chk(A_FLAGS, 32'h0080);
        // Frozen clock enable: an event in that cycle is not seen
        ce <= 1'b0;
        pulse(1);
        ce <= 1'b1;
        rd_chk(A_FLAGS, 32'h0080);
        // Slewing on: done waits for applied to meet target
        cond.target_code <= 16'h0100;
        apb(1'b1, A_SLEW, 32'h1);
        repeat (2) @(posedge pclk);
        chk_bit(slew_en, 1'b1);
        rd_chk(A_FLAGS, 32'h0000);
        chk_bit(irq, 1'b0);
        cond.applied_code <= 16'h0100;
        repeat (3) @(posedge pclk);
        chk_bit(irq, 1'b1);
        rd_chk(A_FLAGS, 32'h0080);
        apb(1'b1, A_SLEW, 32'h0);
        repeat (2) @(posedge pclk);
        chk_bit(slew_en, 1'b0);
        chk_bit(irq, 1'b0);
        cond.target_code <= 16'h0200;
        repeat (3) @(posedge pclk);
        rd_chk(A_FLAGS, 32'h0080);
        apb(1'b1, A_FLAGS, 32'hFFFF);
        chk_bit(err, 1'b0);
        rd_chk(A_FLAGS, 32'h0080);
        tally_and_finish();
    end
endmodule : gsf_general_flags_test
